// ==== hw/bidfd_cfg.svh ====
// Purpose: Constants for the decimal, step and flag datapath slice.
// Assumes: 16-bit data words, 20-bit registers and program counter.
// Notes: Flag positions follow the flags word layout.
`ifndef BIDFD_CFG_SVH
`define BIDFD_CFG_SVH
`define BIDFD_FLG_C 0
`define BIDFD_FLG_Z 1
`define BIDFD_FLG_N 2
`define BIDFD_FLG_GIE 3
`define BIDFD_FLG_CORE_HALT 4
`define BIDFD_FLG_OSC_HALT 5
`define BIDFD_FLG_V 8
`define BIDFD_GIE_CLR_MASK 16'hfff7
`define BIDFD_GIE_SET_MASK 16'h0008
`define BIDFD_FLAGS_RST 16'h0000
`define BIDFD_PC_RST 20'h00000
`define BIDFD_REG_RST 20'h00000
`define BIDFD_NREGS 16
`endif

// ==== hw/bidfd_pkg.sv ====
// Purpose: Types shared by the datapath files.
// Assumes: Nothing beyond the cfg header.
// Notes: Operation codes are the block's command port encoding.
`default_nettype none
package bidfd_pkg;
  typedef enum logic [3:0] {
    BIDFD_OP_NONE = 4'h0,
    BIDFD_OP_DECIMAL_ADD_WITH_CARRY = 4'h1,
    BIDFD_OP_SUB1 = 4'h2,
    BIDFD_OP_SUB2 = 4'h3,
    BIDFD_OP_ADD1 = 4'h4,
    BIDFD_OP_ADD2 = 4'h5,
    BIDFD_OP_INV = 4'h6,
    BIDFD_OP_MASK = 4'h7,
    BIDFD_OP_UNMASK = 4'h8,
    BIDFD_OP_BRC = 4'h9
  } bidfd_op_t;
  typedef enum logic [0:0] {
    BIDFD_IRQ_HOLD = 1'b0,
    BIDFD_IRQ_OPEN = 1'b1
  } bidfd_irq_state_t;
endpackage
`default_nettype wire

// ==== hw/bidfd_regfile.sv ====
// Purpose: Small register file holding the 20-bit destination registers.
// Assumes: One write port and one registered read port.
// Notes: Read data lags the address by one clock.
`default_nettype none
`include "bidfd_cfg.svh"
module bidfd_regfile (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] rd_addr,
  output logic [19:0] rd_data_q,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [19:0] wr_data
);
  logic [19:0] mem_q [`BIDFD_NREGS];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `BIDFD_NREGS; i++) begin
        mem_q[i] <= `BIDFD_REG_RST;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // A write to the address being read returns the new value, so
  // back-to-back operations on one register see each other.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= `BIDFD_REG_RST;
    end else if (wr_en && (wr_addr == rd_addr)) begin
      rd_data_q <= wr_data;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ==== hw/bidfd_top.sv ====
// Purpose: Decimal add, step, invert, interrupt-allow and carry branch slice.
// Assumes: One operation per issue pulse; source operand is given directly.
// Notes: Each arithmetic operation reads its register, then writes back a cycle later; mask, unmask and branch write no register.
//
// Operation
// - Decimal add source plus carry into destination.
// - Decimal add negative follows result top bit.
// - Decimal add zero flag on zero result.
// - Decimal carry when sum beyond four/two digits.
// - Arithmetic keeps halt and allow bits unchanged.
// - Subtract one with its N, Z, C.
// - Subtract one overflow from most negative value.
// - Subtract two with its Z, C.
// - Subtract two overflow from two lowest negatives.
// - Mask-all clears only the allow bit.
// - Unmask-all sets only the allow bit.
// - Next instruction runs before any interrupt.
// - Add one with Z, C, V from value.
// - Add two with its Z and C.
// - Add two overflow from two top positives.
// - Complement destination, negative from sign bit.
// - Complement carry is not-zero, overflow from sign.
// - Branch on carry jumps else falls through.
// - Target is doubled, sign-extended offset plus PC.
`default_nettype none
`include "bidfd_cfg.svh"
module bidfd_top
  import bidfd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue,
  input wire bidfd_op_t op,
  input wire logic byte_mode,
  input wire logic [3:0] dst_sel,
  input wire logic [15:0] src_val,
  input wire logic [9:0] jump_offset,
  input wire logic [19:0] next_pc,
  input wire logic irq_request,
  output logic busy_q,
  output logic done_q,
  output logic [15:0] flags_q,
  output logic [19:0] pc_q,
  output logic branch_taken_q,
  output logic [19:0] result_q,
  output logic irq_take_q
);
  logic [19:0] rd_data;
  logic stage_q;
  bidfd_op_t op_q;
  logic byte_q;
  logic [3:0] dst_q;
  logic [15:0] src_q;
  bidfd_irq_state_t irq_state_q;
  logic irq_gate_q;
  logic wr_en;
  logic [19:0] wr_data;

  bidfd_regfile u_regfile (
    .clk(clk),
    .rst_b(rst_b),
    .rd_addr(dst_sel),
    .rd_data_q(rd_data),
    .wr_en(wr_en),
    .wr_addr(dst_q),
    .wr_data(wr_data)
  );

  // Packed BCD add of one digit with carry in; result digit and carry out.
  function automatic logic [4:0] bcd_digit(input logic [3:0] a, input logic [3:0] b,
                                           input logic cin);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    if (s > 5'd9) begin
      s = s + 5'd6;
      bcd_digit = {1'b1, s[3:0]};
    end else begin
      bcd_digit = {1'b0, s[3:0]};
    end
  endfunction

  // Width-aware top bit of a 16-bit value.
  function automatic logic sign_of(input logic [15:0] v, input logic is_byte);
    sign_of = is_byte ? v[7] : v[15];
  endfunction

  // Width-aware clearing of the unused upper bits, for 20-bit write-back.
  function automatic logic [19:0] fit(input logic [15:0] v, input logic is_byte);
    fit = is_byte ? {12'h000, v[7:0]} : {4'h0, v};
  endfunction

  wire logic [15:0] dst_v = byte_q ? {8'h00, rd_data[7:0]} : rd_data[15:0];
  wire logic [15:0] src_v = byte_q ? {8'h00, src_q[7:0]} : src_q;
  wire logic [15:0] top_v = byte_q ? 16'h0080 : 16'h8000;
  wire logic [15:0] ones_v = byte_q ? 16'h00ff : 16'hffff;
  wire logic c_in = flags_q[`BIDFD_FLG_C];

  // Four chained digits; byte mode uses the carry out of digit one.
  wire logic [4:0] dg0 = bcd_digit(dst_v[3:0], src_v[3:0], c_in);
  wire logic [4:0] dg1 = bcd_digit(dst_v[7:4], src_v[7:4], dg0[4]);
  wire logic [4:0] dg2 = bcd_digit(dst_v[11:8], src_v[11:8], dg1[4]);
  wire logic [4:0] dg3 = bcd_digit(dst_v[15:12], src_v[15:12], dg2[4]);
  wire logic [15:0] bcd_sum = byte_q ? {8'h00, dg1[3:0], dg0[3:0]}
                                     : {dg3[3:0], dg2[3:0], dg1[3:0], dg0[3:0]};
  wire logic bcd_carry = byte_q ? dg1[4] : dg3[4];

  wire logic [15:0] dec1 = (dst_v - 16'h0001) & ones_v;
  wire logic [15:0] dec2 = (dst_v - 16'h0002) & ones_v;
  wire logic [15:0] inc1 = (dst_v + 16'h0001) & ones_v;
  wire logic [15:0] inc2 = (dst_v + 16'h0002) & ones_v;
  wire logic [15:0] inv_v = dst_v ^ ones_v;

  logic [15:0] res;
  logic n_f;
  logic z_f;
  logic c_f;
  logic v_f;
  logic arith;

  // Flag computation per operation; V of decimal add is kept as it was.
  always_comb begin
    res = 16'h0000;
    n_f = flags_q[`BIDFD_FLG_N];
    z_f = flags_q[`BIDFD_FLG_Z];
    c_f = flags_q[`BIDFD_FLG_C];
    v_f = flags_q[`BIDFD_FLG_V];
    arith = 1'b1;
    unique case (op_q)
      BIDFD_OP_DECIMAL_ADD_WITH_CARRY: begin
        res = bcd_sum;
        n_f = sign_of(bcd_sum, byte_q);
        z_f = (bcd_sum == 16'h0000);
        c_f = bcd_carry;
      end
      BIDFD_OP_SUB1: begin
        res = dec1;
        n_f = sign_of(dec1, byte_q);
        z_f = (dst_v == 16'h0001);
        c_f = (dst_v != 16'h0000);
        v_f = (dst_v == top_v);
      end
      BIDFD_OP_SUB2: begin
        res = dec2;
        n_f = sign_of(dec2, byte_q);
        z_f = (dst_v == 16'h0002);
        c_f = (dst_v > 16'h0001);
        v_f = (dst_v == top_v) || (dst_v == (top_v | 16'h0001));
      end
      BIDFD_OP_ADD1: begin
        res = inc1;
        n_f = sign_of(inc1, byte_q);
        z_f = (dst_v == ones_v);
        c_f = (dst_v == ones_v);
        v_f = (dst_v == (top_v - 16'h0001));
      end
      BIDFD_OP_ADD2: begin
        res = inc2;
        n_f = sign_of(inc2, byte_q);
        z_f = (dst_v == (ones_v - 16'h0001));
        c_f = (dst_v >= (ones_v - 16'h0001));
        v_f = (dst_v == (top_v - 16'h0001)) || (dst_v == (top_v - 16'h0002));
      end
      BIDFD_OP_INV: begin
        res = inv_v;
        n_f = sign_of(inv_v, byte_q);
        z_f = (inv_v == 16'h0000);
        c_f = (inv_v != 16'h0000);
        v_f = sign_of(dst_v, byte_q);
      end
      default: begin
        arith = 1'b0;
      end
    endcase
  end

  wire logic in_exec = stage_q;
  assign wr_en = in_exec && arith;
  assign wr_data = fit(res, byte_q);

  // Arithmetic touches only N, Z, C, V; halt and allow bits pass through.
  wire logic [15:0] flags_arith = {flags_q[15:9], v_f, flags_q[7:3], n_f, z_f, c_f};
  wire logic [15:0] flags_mask = flags_q & `BIDFD_GIE_CLR_MASK;
  wire logic [15:0] flags_unmask = flags_q | `BIDFD_GIE_SET_MASK;
  wire logic [15:0] flags_d = !in_exec ? flags_q
                            : arith ? flags_arith
                            : (op_q == BIDFD_OP_MASK) ? flags_mask
                            : (op_q == BIDFD_OP_UNMASK) ? flags_unmask
                            : flags_q;

  // Branch target: offset doubled, sign-extended to 20 bits, added to PC.
  wire logic [19:0] br_off = {{9{jump_offset[9]}}, jump_offset, 1'b0};
  wire logic do_branch = issue && !busy_q && (op == BIDFD_OP_BRC)
                         && flags_q[`BIDFD_FLG_C];
  wire logic [19:0] pc_d = do_branch ? (next_pc + br_off) : next_pc;
  wire logic branch_issue = issue && !busy_q && (op == BIDFD_OP_BRC);
  wire logic start = issue && !busy_q && (op != BIDFD_OP_BRC) && (op != BIDFD_OP_NONE);
  wire logic insn_done = in_exec || branch_issue;

  // Interrupts are taken only with the allow bit set and after one full
  // instruction has completed since unmasking; a request is never taken
  // between unmask and the instruction that follows it.
  wire logic global_irq_allow = flags_q[`BIDFD_FLG_GIE];
  wire logic unmask_now = in_exec && (op_q == BIDFD_OP_UNMASK);
  wire logic irq_gate_d = unmask_now ? 1'b0
                        : (insn_done && global_irq_allow) ? 1'b1
                        : !global_irq_allow ? 1'b0 : irq_gate_q;
  wire bidfd_irq_state_t irq_state_d = irq_gate_d ? BIDFD_IRQ_OPEN : BIDFD_IRQ_HOLD;
  wire logic irq_take_d = irq_request && (irq_state_q == BIDFD_IRQ_OPEN) && global_irq_allow
                          && !unmask_now;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= 1'b0;
      op_q <= BIDFD_OP_NONE;
      byte_q <= 1'b0;
      dst_q <= 4'h0;
      src_q <= 16'h0000;
    end else begin
      stage_q <= start;
      if (start) begin
        op_q <= op;
        byte_q <= byte_mode;
        dst_q <= dst_sel;
        src_q <= src_val;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= `BIDFD_FLAGS_RST;
      pc_q <= `BIDFD_PC_RST;
      branch_taken_q <= 1'b0;
      result_q <= `BIDFD_REG_RST;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      if (branch_issue) begin
        pc_q <= pc_d;
      end
      branch_taken_q <= do_branch;
      if (wr_en) begin
        result_q <= wr_data;
      end
      done_q <= insn_done;
      busy_q <= start;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_gate_q <= 1'b0;
      irq_state_q <= BIDFD_IRQ_HOLD;
      irq_take_q <= 1'b0;
    end else begin
      irq_gate_q <= irq_gate_d;
      irq_state_q <= irq_state_d;
      irq_take_q <= irq_take_d;
    end
  end
endmodule
`default_nettype wire

// ==== bench/bidfd_top_props.sv ====
// Purpose: Port checker for the decimal, step and flag datapath slice.
// Assumes: One clock domain; results appear two edges after an accepted issue.
// Notes: Bound to the design from the bench top.
`default_nettype none
module bidfd_top_props
  import bidfd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue,
  input wire bidfd_op_t op,
  input wire logic byte_mode,
  input wire logic [9:0] jump_offset,
  input wire logic [19:0] next_pc,
  input wire logic busy_q,
  input wire logic [15:0] flags_q,
  input wire logic [19:0] pc_q,
  input wire logic branch_taken_q,
  input wire logic [19:0] result_q,
  input wire logic irq_take_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire acc = issue && !busy_q;
  wire wr = acc && op >= BIDFD_OP_DECIMAL_ADD_WITH_CARRY && op <= BIDFD_OP_INV;
  wire brc = acc && op == BIDFD_OP_BRC;
  wire [19:0] tgt = next_pc + {{9{jump_offset[9]}}, jump_offset, 1'h0};
  a_halt_bits_kept:
    assert property ($stable(flags_q[5:4])) else $error("halt bits moved");
  a_mask_clears_allow:
    assert property (acc && op == BIDFD_OP_MASK |=> ##1
      !flags_q[3] && flags_q[2:0] == $past(flags_q[2:0], 2)) else $error("mask wrong");
  a_unmask_sets_allow:
    assert property (acc && op == BIDFD_OP_UNMASK |=> ##1
      flags_q[3] && flags_q[2:0] == $past(flags_q[2:0], 2)) else $error("unmask wrong");
  a_irq_held_off:
    assert property (acc && op == BIDFD_OP_UNMASK |=> !irq_take_q [*2])
      else $error("interrupt taken too early");
  a_branch_taken:
    assert property (brc && flags_q[0] |=> branch_taken_q && pc_q == $past(tgt))
      else $error("branch target wrong");
  a_branch_falls:
    assert property (brc && !flags_q[0] |=> !branch_taken_q && pc_q == $past(next_pc))
      else $error("fall through wrong");
  a_branch_flags_kept:
    assert property (brc |=> $stable(flags_q)) else $error("branch moved flags");
  a_byte_upper_clear:
    assert property (wr && byte_mode |=> ##1 result_q[19:8] == 12'h000)
      else $error("byte upper bits set");
  a_word_upper_clear:
    assert property (wr && !byte_mode |=> ##1 result_q[19:16] == 4'h0)
      else $error("word upper bits set");
  a_inv_flag_link:
    assert property (acc && op == BIDFD_OP_INV && !byte_mode |=> ##1
      flags_q[0] != flags_q[1] && flags_q[2] == result_q[15]) else $error("invert flags wrong");
endmodule
`default_nettype wire

// ==== bench/bcd_incdec_flag_datapath_tb_top.sv ====
// Purpose: Directed bench for the decimal, step and flag datapath slice.
// Assumes: Registers start at zero and are loaded by decimal add from zero.
// Notes: Scratch register 15 toggles to clear carry, since no op clears it directly.
`default_nettype none
`include "bidfd_cfg.svh"
module bcd_incdec_flag_datapath_tb_top;
  import bidfd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_b = 1'h0, issue = 1'h0, byte_mode = 1'h0, irq_request = 1'h0;
  bidfd_op_t op = BIDFD_OP_NONE;
  logic [3:0] dst_sel = 4'h0;
  logic [15:0] src_val = 16'h0000;
  logic [9:0] jump_offset = 10'h000;
  logic [19:0] next_pc = 20'h00000;
  logic busy_q, done_q, branch_taken_q, irq_take_q;
  logic [15:0] flags_q;
  logic [19:0] pc_q, result_q;
  logic [15:0] rf [16];
  logic [15:0] ef = 16'h0000;
  int miscompares = 0, cmp_count = 0;
  always #2 clk = ~clk;
  bidfd_top i_dut (.clk(clk), .rst_b(rst_b), .issue(issue), .op(op), .byte_mode(byte_mode),
    .dst_sel(dst_sel), .src_val(src_val), .jump_offset(jump_offset), .next_pc(next_pc),
    .irq_request(irq_request), .busy_q(busy_q), .done_q(done_q), .flags_q(flags_q),
    .pc_q(pc_q), .branch_taken_q(branch_taken_q), .result_q(result_q),
    .irq_take_q(irq_take_q));
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hold keeps issue high while busy, which the design must ignore.
  task automatic run(input bidfd_op_t o, input logic b, input logic [3:0] d,
    input logic [15:0] s, input logic hold);
    logic [15:0] m, x, r;
    logic [16:0] t, k;
    logic [4:0] q;
    logic c, hx, wr;
    m = b ? 16'h00ff : 16'hffff;
    x = rf[d] & m;
    r = x;
    c = ef[0];
    hx = b ? x[7] : x[15];
    k = (o == BIDFD_OP_ADD1 || o == BIDFD_OP_SUB1) ? 17'h1 : 17'h2;
    wr = o != BIDFD_OP_MASK && o != BIDFD_OP_UNMASK;
    if (o == BIDFD_OP_ADD1 || o == BIDFD_OP_ADD2) begin
      t = {1'h0, x} + k;
      r = t[15:0] & m;
      ef[0] = t > {1'h0, m};
      ef[8] = !hx && (b ? r[7] : r[15]);
    end else if (o == BIDFD_OP_SUB1 || o == BIDFD_OP_SUB2) begin
      t = {1'h0, x} - k;
      r = t[15:0] & m;
      ef[0] = {1'h0, x} >= k;
      ef[8] = hx && !(b ? r[7] : r[15]);
    end else if (o == BIDFD_OP_INV) begin
      r = ~x & m;
      ef[0] = r != 16'h0000;
      ef[8] = hx;
    end else if (o == BIDFD_OP_DECIMAL_ADD_WITH_CARRY) begin
      for (int i = 0; i < (b ? 2 : 4); i++) begin
        q = x[4*i+:4] + s[4*i+:4] + c;
        c = q > 5'h09;
        r[4*i+:4] = c ? q[3:0] + 4'h6 : q[3:0];
      end
      ef[0] = c;
    end else begin
      ef[3] = o == BIDFD_OP_UNMASK;
    end
    if (wr) begin
      ef[2] = b ? r[7] : r[15];
      ef[1] = r == 16'h0000;
      rf[d] = r;
    end
    @(posedge clk);
    issue <= 1'h1;
    op <= o;
    byte_mode <= b;
    dst_sel <= d;
    src_val <= s;
    @(posedge clk);
    issue <= hold;
    #1 chk("busy", 20'h1, {19'h0, busy_q});
    @(posedge clk);
    issue <= 1'h0;
    #1 chk("done", 20'h1, {19'h0, done_q});
    chk("flags", {4'h0, ef}, {4'h0, flags_q});
    if (wr) chk("result", {4'h0, r}, result_q);
  endtask
  task automatic clrc;
    while (ef[0]) run(BIDFD_OP_INV, 1'h0, 4'hf, 16'h0000, 1'h0);
  endtask
  task automatic ld(input logic [3:0] d, input logic b, input logic [15:0] v);
    clrc();
    run(BIDFD_OP_DECIMAL_ADD_WITH_CARRY, b, d, v, 1'h0);
  endtask
  task automatic br(input logic [9:0] off, input logic [19:0] pc);
    logic [19:0] e;
    e = ef[0] ? pc + {{9{off[9]}}, off, 1'h0} : pc;
    @(posedge clk);
    issue <= 1'h1;
    op <= BIDFD_OP_BRC;
    jump_offset <= off;
    next_pc <= pc;
    @(posedge clk);
    issue <= 1'h0;
    #1 chk("pc", e, pc_q);
    chk("taken", {19'h0, ef[0]}, {19'h0, branch_taken_q});
    chk("flags", {4'h0, ef}, {4'h0, flags_q});
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    foreach (rf[i]) rf[i] = 16'h0000;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    irq_request <= 1'h1;
    ld(4'h1, 1'h0, 16'h7999);
    run(BIDFD_OP_DECIMAL_ADD_WITH_CARRY, 1'h0, 4'h1, 16'h0001, 1'h0);
    run(BIDFD_OP_DECIMAL_ADD_WITH_CARRY, 1'h0, 4'h1, 16'h2000, 1'h0);
    run(BIDFD_OP_DECIMAL_ADD_WITH_CARRY, 1'h0, 4'h1, 16'h0000, 1'h0);
    ld(4'h2, 1'h1, 16'h0099);
    run(BIDFD_OP_DECIMAL_ADD_WITH_CARRY, 1'h1, 4'h2, 16'h0001, 1'h1);
    ld(4'h3, 1'h1, 16'h0079);
    run(BIDFD_OP_DECIMAL_ADD_WITH_CARRY, 1'h1, 4'h3, 16'h0001, 1'h0);
    $display("test decimal done");
    ld(4'h4, 1'h0, 16'h8000);
    run(BIDFD_OP_SUB1, 1'h0, 4'h4, 16'h0000, 1'h0);
    run(BIDFD_OP_SUB1, 1'h0, 4'h4, 16'h0000, 1'h0);
    ld(4'h5, 1'h0, 16'h8001);
    run(BIDFD_OP_SUB2, 1'h0, 4'h5, 16'h0000, 1'h0);
    ld(4'h6, 1'h0, 16'h0001);
    run(BIDFD_OP_SUB1, 1'h0, 4'h6, 16'h0000, 1'h0);
    run(BIDFD_OP_SUB1, 1'h0, 4'h6, 16'h0000, 1'h0);
    ld(4'h7, 1'h0, 16'h0002);
    run(BIDFD_OP_SUB2, 1'h0, 4'h7, 16'h0000, 1'h0);
    run(BIDFD_OP_SUB2, 1'h0, 4'h7, 16'h0000, 1'h0);
    ld(4'h8, 1'h1, 16'h0080);
    run(BIDFD_OP_SUB1, 1'h1, 4'h8, 16'h0000, 1'h0);
    ld(4'h9, 1'h1, 16'h0081);
    run(BIDFD_OP_SUB2, 1'h1, 4'h9, 16'h0000, 1'h0);
    $display("test decrement done");
    run(BIDFD_OP_ADD2, 1'h0, 4'h4, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD1, 1'h0, 4'h5, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD2, 1'h0, 4'h7, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD1, 1'h0, 4'h6, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD1, 1'h1, 4'h9, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD2, 1'h1, 4'h8, 16'h0000, 1'h0);
    run(BIDFD_OP_INV, 1'h1, 4'ha, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD2, 1'h1, 4'ha, 16'h0000, 1'h0);
    run(BIDFD_OP_ADD1, 1'h1, 4'h4, 16'h0000, 1'h0);
    $display("test increment done");
    run(BIDFD_OP_INV, 1'h0, 4'h1, 16'h0000, 1'h0);
    run(BIDFD_OP_INV, 1'h0, 4'h1, 16'h0000, 1'h0);
    run(BIDFD_OP_INV, 1'h1, 4'h3, 16'h0000, 1'h0);
    br(10'h200, 20'h10000);
    br(10'h1ff, 20'hffffe);
    clrc();
    br(10'h005, 20'h00100);
    $display("test invert and branch done");
    run(BIDFD_OP_UNMASK, 1'h0, 4'h0, 16'h0000, 1'h0);
    chk("irq take", 20'h0, {19'h0, irq_take_q});
    run(BIDFD_OP_ADD1, 1'h0, 4'hb, 16'h0000, 1'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq take", 20'h1, {19'h0, irq_take_q});
    run(BIDFD_OP_MASK, 1'h0, 4'h0, 16'h0000, 1'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq take", 20'h0, {19'h0, irq_take_q});
    $display("test interrupt allow done");
    final_report();
  end
endmodule
bind bidfd_top bidfd_top_props i_props (.clk(clk), .rst_b(rst_b), .issue(issue), .op(op),
  .byte_mode(byte_mode), .jump_offset(jump_offset), .next_pc(next_pc), .busy_q(busy_q),
  .flags_q(flags_q), .pc_q(pc_q), .branch_taken_q(branch_taken_q), .result_q(result_q),
  .irq_take_q(irq_take_q));
`default_nettype wire
